// ### sqv_pkg.sv
package sqv_pkg;
   // Register offsets (byte addresses)
   localparam logic [11:0] QUEUE_MANAGEMENT_CONTROL_OFS = 12'h390;
   localparam logic [11:0] PACKET_MEMORY_FREE_BLOCKS_OFS = 12'h3AC;
   localparam logic [11:0] VLAN_ENTRY_WORD_ZERO_OFS = 12'h400;
   localparam logic [11:0] VLAN_ENTRY_WORD_TWO_OFS = 12'h408;
   localparam logic [11:0] MEMBERSHIP_CHECK_OFS = 12'h3B0;
   localparam logic [11:0] PACKET_MEMORY_EVENT_OFS = 12'h3B4;
   // Queue control fields
   localparam int PRIO_MAP_LSB = 6;
   localparam int UNICAST_DISCARD_BIT = 1;
   localparam int QCTL_RW_MSB = 7;
   localparam logic [1:0] PRIO_MAP_RESET = 2'h2;
   localparam logic UNICAST_DISCARD_RESET = 1'h1;
   localparam logic [5:0] QCTL_LOW_RESET = 6'h00;
   localparam logic [1:0] MAP_CODE_ONLY3 = 2'h0;
   localparam logic [1:0] MAP_CODE_UNUSED = 2'h1;
   localparam logic [1:0] MAP_CODE_HALF = 2'h2;
   localparam logic [1:0] MAP_CODE_ALL_BUT0 = 2'h3;
   // Free block count
   localparam int FREE_COUNT_LSB = 16;
   localparam int FREE_COUNT_W = 11;
   localparam logic [10:0] FREE_COUNT_MAX = 11'h3F7;
   // VLAN entry word zero fields
   localparam int VALID_BIT = 31;
   localparam int FWD_OPT_BIT = 27;
   localparam int PRIORITY_LSB = 24;
   localparam int MSTI_LSB = 12;
   localparam int FID_LSB = 0;
   localparam logic [31:0] VLAN_ENTRY_MASK = 32'h8F00707F;
   localparam logic [31:0] VLAN_ENTRY_RESET = 32'h00000000;
   localparam logic [2:0] PORT_FORWARD_RESET = 3'h0;
endpackage

// ### sqv_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE_01] Two-queue map field bits 7:6, reset 10b
// [RULE_02] Map code selects high queue threshold
// [RULE_03] Discard set: restrict to membership ports
// [RULE_04] Discard clear: unicast frames not restricted
// [RULE_05] Discard clear, mirrored unicast frame dropped
// [RULE_06] Free block count read-only, bits 26:16
// [RULE_07] Free count resets to 0x3F7 when empty
// [RULE_08] VLAN entry valid bit 31, reset 0
// [RULE_09] Forward option set: use entry port map
// [RULE_10] Forward option clear: use other port sources
// [RULE_11] Priority 26:24, spanning index 14:12, reset zero
// [RULE_12] Filter identifier held in bits 6:0
// [RULE_13] Entry port forward bits need forward option
// [RULE_14] Reserved read-only bits read zero
module sqv_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Queue mapping lookup
   input wire logic [1:0] regen_priority,
   output logic high_queue,
   // Forwarding decision
   input wire logic [2:0] membership_ports,
   input wire logic [2:0] lookup_ports,
   input wire logic single_destination,
   input wire logic mirror_active,
   output logic [2:0] egress_ports,
   output logic frame_drop,
   // Packet memory block usage
   input wire logic block_alloc,
   input wire logic block_free,
   // VLAN entry fields toward the lookup engine
   output logic entry_valid,
   output logic forward_option_select,
   output logic [2:0] entry_priority,
   output logic [2:0] entry_msti,
   output logic [6:0] filter_identifier
);
   logic [7:0] qctl;
   logic [10:0] free_block_count;
   logic [31:0] vlan_word0;
   logic [2:0] port_forward;
   logic [31:0] next_rdata;
   logic [2:0] next_ports;
   logic next_drop;
   logic next_high;

   function automatic logic map_to_high(input logic [1:0] code, input logic [1:0] prio);
      case (code)
         sqv_pkg::MAP_CODE_ONLY3: map_to_high = (prio == 2'h3);
         sqv_pkg::MAP_CODE_HALF: map_to_high = (prio >= 2'h2);
         sqv_pkg::MAP_CODE_ALL_BUT0: map_to_high = (prio != 2'h0);
         default: map_to_high = (prio >= 2'h2);
      endcase
   endfunction

   // Queue control word; bits 5:2 and 0 are plain storage
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         qctl <= {sqv_pkg::PRIO_MAP_RESET, sqv_pkg::QCTL_LOW_RESET[5:2], // [RULE_01]
                  sqv_pkg::UNICAST_DISCARD_RESET, sqv_pkg::QCTL_LOW_RESET[0]};
      end else if (reg_wr && reg_addr == sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS) begin
         qctl <= reg_wdata[sqv_pkg::QCTL_RW_MSB:0];
      end
   end

   AST_QCTL_WRITE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_01]
      (reg_wr && reg_addr == sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS)
      |=> qctl == $past(reg_wdata[sqv_pkg::QCTL_RW_MSB:0]))
      else $error("queue control write lost");
   AST_QCTL_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_01]
      !(reg_wr && reg_addr == sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS) |=> $stable(qctl))
      else $error("queue control changed without a write");

   // Free block counter; alloc and free together cancel
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         free_block_count <= sqv_pkg::FREE_COUNT_MAX; // [RULE_07]
      end else if (block_alloc && !block_free && free_block_count != 11'h000) begin
         free_block_count <= free_block_count - 11'h001; // [RULE_06]
      end else if (block_free && !block_alloc && free_block_count != sqv_pkg::FREE_COUNT_MAX) begin
         free_block_count <= free_block_count + 11'h001;
      end
   end

   AST_FREE_UP: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
      (block_free && !block_alloc && free_block_count != sqv_pkg::FREE_COUNT_MAX)
      |=> free_block_count == $past(free_block_count) + 11'h001)
      else $error("free block count did not track release");
   AST_FREE_BOTH: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
      (block_alloc == block_free) |=> $stable(free_block_count))
      else $error("free block count moved without net change");
   AST_FREE_STEP: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
      1'b1 |=> free_block_count == $past(free_block_count)
      || free_block_count == $past(free_block_count) + 11'h001
      || free_block_count == $past(free_block_count) - 11'h001)
      else $error("free block count jumped");
   AST_FREE_FLOOR: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
      (free_block_count == 11'h000 && !block_free) |=> free_block_count == 11'h000)
      else $error("free block count wrapped below zero");
   AST_FREE_CEIL: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_07]
      (free_block_count == sqv_pkg::FREE_COUNT_MAX && !block_alloc)
      |=> free_block_count == sqv_pkg::FREE_COUNT_MAX)
      else $error("free block count passed its maximum");
   AST_FREE_RESET: assert property (@(posedge mclk) // [RULE_07]
      $rose(reset_n) |-> free_block_count == sqv_pkg::FREE_COUNT_MAX)
      else $error("free block count reset value wrong");

   // VLAN entry staging words
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         vlan_word0 <= sqv_pkg::VLAN_ENTRY_RESET; // [RULE_08] [RULE_11]
         port_forward <= sqv_pkg::PORT_FORWARD_RESET;
      end else if (reg_wr) begin
         if (reg_addr == sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS) begin
            vlan_word0 <= reg_wdata & sqv_pkg::VLAN_ENTRY_MASK; // [RULE_14]
         end
         if (reg_addr == sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS) begin
            port_forward <= reg_wdata[2:0];
         end
      end
   end

   AST_WORD0_WRITE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      (reg_wr && reg_addr == sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS)
      |=> vlan_word0 == ($past(reg_wdata) & sqv_pkg::VLAN_ENTRY_MASK))
      else $error("entry word zero write lost");
   AST_WORD0_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
      !(reg_wr && reg_addr == sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS)
      |=> $stable(vlan_word0))
      else $error("entry word zero changed without a write");
   AST_WORD2_WRITE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_13]
      (reg_wr && reg_addr == sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS)
      |=> port_forward == $past(reg_wdata[2:0]))
      else $error("port forward write lost");
   AST_WORD2_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_13]
      !(reg_wr && reg_addr == sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS)
      |=> $stable(port_forward))
      else $error("port forward changed without a write");
   AST_WORD0_RESET: assert property (@(posedge mclk) // [RULE_08]
      $rose(reset_n) |-> vlan_word0 == sqv_pkg::VLAN_ENTRY_RESET
      && port_forward == sqv_pkg::PORT_FORWARD_RESET)
      else $error("entry staging reset value wrong");

   // Read mux
   always_comb begin
      next_rdata = 32'h00000000;
      case (reg_addr)
         sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS: next_rdata = {24'h000000, qctl};
         sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS:
            next_rdata = {5'h00, free_block_count, 16'h0000}; // [RULE_06] [RULE_14]
         sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS: next_rdata = vlan_word0;
         sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS: next_rdata = {29'h00000000, port_forward};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside a read");
   AST_RD_QCTL: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      (reg_rd && reg_addr == sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS)
      |=> reg_rdata == {24'h000000, $past(qctl)})
      else $error("queue control read wrong");
   AST_RD_FREE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
      (reg_rd && reg_addr == sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS)
      |=> reg_rdata[sqv_pkg::FREE_COUNT_LSB +: sqv_pkg::FREE_COUNT_W] == $past(free_block_count))
      else $error("free block count read wrong");
   AST_RD_FREE_RSVD: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      (reg_rd && reg_addr == sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS)
      |=> reg_rdata[31:27] == 5'h00 && reg_rdata[15:0] == 16'h0000)
      else $error("free block register reserved bits set");
   AST_RD_WORD0: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
      (reg_rd && reg_addr == sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS)
      |=> reg_rdata == $past(vlan_word0))
      else $error("entry word zero read wrong");
   AST_RD_WORD2: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      (reg_rd && reg_addr == sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS)
      |=> reg_rdata == {29'h00000000, $past(port_forward)})
      else $error("port forward read wrong");
   AST_RD_UNMAPPED: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      (reg_rd && reg_addr != sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS
       && reg_addr != sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS
       && reg_addr != sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS
       && reg_addr != sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS) |=> reg_rdata == 32'h00000000)
      else $error("unmapped address read nonzero");

   // Forwarding decision
   always_comb begin
      next_drop = 1'b0;
      if (vlan_word0[sqv_pkg::FWD_OPT_BIT]) begin
         next_ports = port_forward; // [RULE_09] [RULE_13]
      end else begin
         next_ports = lookup_ports; // [RULE_10]
      end
      if (qctl[sqv_pkg::UNICAST_DISCARD_BIT]) begin
         next_ports = next_ports & membership_ports; // [RULE_03]
      end else if (!single_destination) begin
         next_ports = next_ports & membership_ports; // [RULE_04]
      end else if (mirror_active) begin
         next_drop = 1'b1; // [RULE_05]
         next_ports = 3'h0;
      end
      next_high = map_to_high(qctl[sqv_pkg::PRIO_MAP_LSB +: 2], regen_priority); // [RULE_02]
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         egress_ports <= 3'h0;
         frame_drop <= 1'b0;
         high_queue <= 1'b0;
      end else begin
         egress_ports <= next_ports;
         frame_drop <= next_drop;
         high_queue <= next_high;
      end
   end

   AST_MAP_ONLY3: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
      (qctl[sqv_pkg::PRIO_MAP_LSB +: 2] == sqv_pkg::MAP_CODE_ONLY3)
      |=> high_queue == ($past(regen_priority) == 2'h3))
      else $error("two-queue map code 00 misrouted");
   AST_MAP_ALL_BUT0: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
      (qctl[sqv_pkg::PRIO_MAP_LSB +: 2] == sqv_pkg::MAP_CODE_ALL_BUT0)
      |=> high_queue == ($past(regen_priority) != 2'h0))
      else $error("two-queue map code 11 misrouted");
   AST_MAP_UNUSED: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
      (qctl[sqv_pkg::PRIO_MAP_LSB +: 2] == sqv_pkg::MAP_CODE_UNUSED)
      |=> high_queue == ($past(regen_priority) >= 2'h2))
      else $error("unused map code not treated as code 10");
   AST_MAP_PRIO3: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
      (regen_priority == 2'h3) |=> high_queue)
      else $error("priority 3 not sent to the high queue");
   AST_OTHER_SOURCES: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_10]
      (!vlan_word0[sqv_pkg::FWD_OPT_BIT] && qctl[sqv_pkg::UNICAST_DISCARD_BIT])
      |=> egress_ports == ($past(lookup_ports) & $past(membership_ports)))
      else $error("lookup port map not used");
   AST_MULTI_RESTRICT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_04]
      (!qctl[sqv_pkg::UNICAST_DISCARD_BIT] && !single_destination)
      |=> (egress_ports & ~$past(membership_ports)) == 3'h0 && !frame_drop)
      else $error("multi-destination frame left membership ports");
   AST_NO_DROP: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_05]
      (qctl[sqv_pkg::UNICAST_DISCARD_BIT] || !single_destination || !mirror_active)
      |=> !frame_drop)
      else $error("frame dropped without mirroring");
   AST_DROP_PORTS: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_05]
      frame_drop |-> egress_ports == 3'h0)
      else $error("dropped frame still has egress ports");
   AST_FWD_UNRESTRICT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_13]
      (vlan_word0[sqv_pkg::FWD_OPT_BIT] && !qctl[sqv_pkg::UNICAST_DISCARD_BIT]
       && single_destination && !mirror_active) |=> egress_ports == $past(port_forward))
      else $error("entry port map not applied to single destination");
   AST_PORTS_SOURCE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_13]
      !vlan_word0[sqv_pkg::FWD_OPT_BIT] |=> (egress_ports & ~$past(lookup_ports)) == 3'h0)
      else $error("entry port map used without forward option");
   AST_OUT_RESET: assert property (@(posedge mclk) // [RULE_03]
      $rose(reset_n) |-> egress_ports == 3'h0 && !frame_drop && !high_queue)
      else $error("decision outputs not zero after reset");

   // Entry fields registered toward the lookup engine
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         entry_valid <= 1'b0;
         forward_option_select <= 1'b0;
         entry_priority <= 3'h0;
         entry_msti <= 3'h0;
         filter_identifier <= 7'h00;
      end else begin
         entry_valid <= vlan_word0[sqv_pkg::VALID_BIT]; // [RULE_08]
         forward_option_select <= vlan_word0[sqv_pkg::FWD_OPT_BIT];
         entry_priority <= vlan_word0[sqv_pkg::PRIORITY_LSB +: 3]; // [RULE_11]
         entry_msti <= vlan_word0[sqv_pkg::MSTI_LSB +: 3];
         filter_identifier <= vlan_word0[sqv_pkg::FID_LSB +: 7]; // [RULE_12]
      end
   end

   AST_ENTRY_VALID: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_08]
      1'b1 |=> entry_valid == $past(vlan_word0[sqv_pkg::VALID_BIT]))
      else $error("valid flag not passed on");
   AST_ENTRY_FWD: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_09]
      1'b1 |=> forward_option_select == $past(vlan_word0[sqv_pkg::FWD_OPT_BIT]))
      else $error("forward option not passed on");
   AST_ENTRY_FIELDS: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_11]
      1'b1 |=> entry_priority == $past(vlan_word0[sqv_pkg::PRIORITY_LSB +: 3])
      && entry_msti == $past(vlan_word0[sqv_pkg::MSTI_LSB +: 3]))
      else $error("priority or spanning index not passed on");
   AST_ENTRY_FID: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_12]
      1'b1 |=> filter_identifier == $past(vlan_word0[sqv_pkg::FID_LSB +: 7]))
      else $error("filter identifier not passed on");
   AST_ENTRY_RESET: assert property (@(posedge mclk) // [RULE_11]
      $rose(reset_n) |-> !entry_valid && entry_priority == 3'h0 && entry_msti == 3'h0
      && filter_identifier == 7'h00)
      else $error("entry outputs not zero after reset");

   AST_MAP_HALF: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
      (qctl[7:6] == 2'h2) |=> (high_queue == ($past(regen_priority) >= 2'h2)))
      else $error("two-queue map code 10 misrouted");
   AST_MAP_ONE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_02]
      (qctl[7:6] == 2'h3 && regen_priority == 2'h0) |=> !high_queue)
      else $error("priority 0 went high with code 11");
   AST_QCTL_RESET: assert property (@(posedge mclk) // [RULE_01]
      $rose(reset_n) |-> qctl[7:6] == 2'h2 && qctl[1])
      else $error("queue control reset value wrong");
   AST_RESTRICT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_03]
      qctl[1] |=> (egress_ports & ~$past(membership_ports)) == 3'h0)
      else $error("frame left membership ports");
   AST_UNRESTRICT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_04]
      (!qctl[1] && single_destination && !mirror_active && !vlan_word0[27])
      |=> egress_ports == $past(lookup_ports))
      else $error("single destination frame was restricted");
   AST_MIRROR_DROP: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_05]
      (!qctl[1] && single_destination && mirror_active) |=> frame_drop && egress_ports == 3'h0)
      else $error("mirrored unicast frame not dropped");
   AST_FREE_RANGE: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_06]
      (block_alloc && !block_free && free_block_count != 11'h000)
      |=> free_block_count == $past(free_block_count) - 11'h001)
      else $error("free block count did not track allocation");
   AST_FREE_MAX: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_07]
      free_block_count <= sqv_pkg::FREE_COUNT_MAX)
      else $error("free block count above maximum");
   AST_FWD_OPT: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_09]
      (vlan_word0[27] && qctl[1]) |=> egress_ports == ($past(port_forward) & $past(membership_ports)))
      else $error("entry port map not applied");
   AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE_14]
      (vlan_word0 & ~sqv_pkg::VLAN_ENTRY_MASK) == 32'h00000000)
      else $error("reserved entry bits set");
endmodule // sqv_regs

// ### switch_queue_vlan_entry_regs_test.sv
`timescale 1ns/100ps
module switch_queue_vlan_entry_regs_test;
   logic mclk, reset_n, reg_wr, reg_rd, single_destination, mirror_active;
   logic block_alloc, block_free, high_queue, frame_drop, entry_valid, forward_option_select;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0] regen_priority;
   logic [2:0] membership_ports, lookup_ports, egress_ports, entry_priority, entry_msti;
   logic [6:0] filter_identifier;
   int miscompares = 0;
   int comparisons = 0;
   sqv_regs i_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .regen_priority(regen_priority), .high_queue(high_queue),
      .membership_ports(membership_ports), .lookup_ports(lookup_ports),
      .single_destination(single_destination), .mirror_active(mirror_active),
      .egress_ports(egress_ports), .frame_drop(frame_drop), .block_alloc(block_alloc),
      .block_free(block_free), .entry_valid(entry_valid),
      .forward_option_select(forward_option_select), .entry_priority(entry_priority),
      .entry_msti(entry_msti), .filter_identifier(filter_identifier));
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      check(reg_rdata, exp);
   endtask
   // Decision inputs with port forward 5, membership 3, lookup 4
   task fwd(input logic disc, input logic fo, input logic sd, input logic mir,
            input logic [2:0] exp_e, input logic exp_d);
      wr(sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS, {24'h000000, 6'h20, disc, 1'h0});
      wr(sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS, {4'h8, fo, 27'h0000000});
      @(posedge mclk);
      single_destination <= sd;
      mirror_active <= mir;
      repeat (3) @(posedge mclk);
      #1;
      check({28'h0000000, frame_drop, egress_ports}, {28'h0000000, exp_d, exp_e});
   endtask
   task test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      logic [1:0] code;
      logic [2:0] thr;
      reset_n = 1'h0;
      {reg_wr, reg_rd, single_destination, mirror_active, block_alloc, block_free} = 6'h00;
      reg_addr = 12'h000;
      reg_wdata = 32'h00000000;
      regen_priority = 2'h0;
      membership_ports = 3'h3;
      lookup_ports = 3'h4;
      repeat (5) @(posedge mclk);
      reset_n <= 1'h1;
      rd(sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS, 32'h00000082);
      rd(sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS, 32'h00000000);
      rd(sqv_pkg::MEMBERSHIP_CHECK_OFS, 32'h00000000);
      // Free at maximum must saturate
      @(posedge mclk);
      block_free <= 1'h1;
      repeat (2) @(posedge mclk);
      block_free <= 1'h0;
      rd(sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS, 32'h03F70000);
      wr(sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS, 32'h00000000);
      block_alloc <= 1'h1;
      repeat (3) @(posedge mclk);
      block_free <= 1'h1;
      repeat (2) @(posedge mclk);
      {block_alloc, block_free} <= 2'h0;
      rd(sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS, 32'h03F40000);
      @(posedge mclk) block_free <= 1'h1;
      repeat (3) @(posedge mclk);
      block_free <= 1'h0;
      rd(sqv_pkg::PACKET_MEMORY_FREE_BLOCKS_OFS, 32'h03F70000);
      wr(sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS, 32'hFFFFFFFF);
      rd(sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS, 32'h000000FF);
      // Each map code against each priority; code 01 behaves as 10
      for (int c = 0; c < 4; c++) begin
         code = c[1:0];
         thr = (code == 2'h0) ? 3'h3 : (code == 2'h3) ? 3'h1 : 3'h2;
         wr(sqv_pkg::QUEUE_MANAGEMENT_CONTROL_OFS, {24'h000000, code, 6'h02});
         for (int p = 0; p < 4; p++) begin
            @(posedge mclk);
            regen_priority <= p[1:0];
            repeat (2) @(posedge mclk);
            #1;
            check({31'h0, high_queue}, {31'h0, ({1'h0, p[1:0]} >= thr)});
         end
      end
      wr(sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS, 32'hFFFFFFFD);
      rd(sqv_pkg::VLAN_ENTRY_WORD_TWO_OFS, 32'h00000005);
      fwd(1'h1, 1'h0, 1'h1, 1'h0, 3'h0, 1'h0);
      fwd(1'h1, 1'h1, 1'h0, 1'h0, 3'h1, 1'h0);
      fwd(1'h0, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
      fwd(1'h0, 1'h0, 1'h1, 1'h0, 3'h4, 1'h0);
      fwd(1'h0, 1'h1, 1'h1, 1'h0, 3'h5, 1'h0);
      fwd(1'h0, 1'h0, 1'h1, 1'h1, 3'h0, 1'h1);
      wr(sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS, 32'hFFFFFFFF);
      @(posedge mclk);
      #1;
      check({entry_valid, forward_option_select, entry_priority}, 5'h1F);
      check({entry_msti, filter_identifier}, 10'h3FF);
      rd(sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS, 32'h8F00707F);
      wr(sqv_pkg::VLAN_ENTRY_WORD_ZERO_OFS, 32'h7200502A);
      @(posedge mclk);
      #1;
      check({entry_valid, entry_priority, entry_msti}, 7'h15);
      check({25'h0, filter_identifier}, 32'h0000002A);
      test_done;
   end
endmodule // switch_queue_vlan_entry_regs_test
